//--- core/seei_consts.vh
// Constants of the serial EEPROM SPI slave interface.
`ifndef SEEI_CONSTS_VH
`define SEEI_CONSTS_VH

// Byte geometry of the serial link.
`define SEEI_BYTE_W 8
`define SEEI_BIT_CNT_W 3
`define SEEI_BIT_LAST 3'h7
`define SEEI_BYTE_CNT_W 2

// Value that an erased array byte reads back as.
`define SEEI_ERASED_BYTE 8'hff

// Delivery values of the status protection bits.
`define SEEI_RST_WRITE_LOCK 1'b0
`define SEEI_RST_PROTECT_HI 1'b0
`define SEEI_RST_PROTECT_LO 1'b0

// Bit positions in the status write data word.
`define SEEI_STAT_WRITE_LOCK 7
`define SEEI_STAT_PROTECT_HI 3
`define SEEI_STAT_PROTECT_LO 2

// Default depth of the receive buffer.
`define SEEI_FIFO_DEPTH 16
`define SEEI_FIFO_AW 4

`endif

//--- core/seei_spi_slave.v
// SPI slave bit interface of a serial EEPROM, with its receive buffer.
`timescale 1ns/1ps
`include "seei_consts.vh"

// Overview of operation
// - Unloaded output bytes read as all ones, like an erased array.
// - Write lock and both protect level bits reset to zero.
// - Incoming bytes are assembled most significant bit first.
// - Input bits are captured on rising clock edges after select falls.
// - Output bytes are sent most significant bit first.
// - First output bit appears on the falling edge after the instruction byte.
// - Output driven only while selected; master selects one device at a time.
// - Both clock modes 0 and 3 work; rising samples, falling shifts out.

// ---------------------------------------------------------------------------
// Receive buffer
// ---------------------------------------------------------------------------

// Synchronous FIFO with a registered head word.
module seei_fifo #(
  parameter WIDTH = `SEEI_BYTE_W,
  parameter DEPTH = `SEEI_FIFO_DEPTH,
  parameter AW = `SEEI_FIFO_AW
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output reg [WIDTH-1:0] rd_data_out,
  output reg rd_valid_out,
  input wire rd_ready_in
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_wr;
  wire do_rd;
  wire head_take;

  // Pointer advance that wraps at the configured depth.
  function [AW-1:0] nxt_ptr;
    input [AW-1:0] ptr;
    begin
      if (ptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        nxt_ptr = {AW{1'b0}};
      end else begin
        nxt_ptr = ptr + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Full is honest: the storage array alone counts, the head word is extra.
  assign wr_ready_out = (count_ff != DEPTH[AW:0]);
  assign do_wr = wr_valid_in && wr_ready_out;
  // The head register refills whenever it is empty or being popped.
  assign head_take = !rd_valid_out || rd_ready_in;
  assign do_rd = head_take && (count_ff != {(AW+1){1'b0}});

  // Storage writes.
  // The array has no reset; the pointers, the count and the head register get one.
  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= wr_data_in;
    end
  end

  // Pointers, occupancy and the head register.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      rd_data_out <= {WIDTH{1'b0}};
      rd_valid_out <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= nxt_ptr(wr_ptr_ff);
      end
      if (do_rd) begin
        rd_ptr_ff <= nxt_ptr(rd_ptr_ff);
        rd_data_out <= mem[rd_ptr_ff];
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
      if (head_take) begin
        rd_valid_out <= do_rd;
      end
    end
  end

endmodule

// ---------------------------------------------------------------------------
// Serial interface
// ---------------------------------------------------------------------------

// Oversampled SPI slave in clock modes 0 and 3.
module seei_spi_slave #(
  parameter FIFO_DEPTH = `SEEI_FIFO_DEPTH,
  parameter FIFO_AW = `SEEI_FIFO_AW
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire spi_clk_in,
  input wire spi_sel_n_in,
  input wire spi_din_in,
  output reg spi_dout_out,
  output reg spi_dout_oe_out,
  output wire [`SEEI_BYTE_W-1:0] rx_data_out,
  output wire rx_valid_out,
  input wire rx_ready_in,
  output reg rx_overflow_out,
  input wire [`SEEI_BYTE_W-1:0] tx_data_in,
  input wire tx_valid_in,
  output reg tx_ready_out,
  input wire status_wr_in,
  input wire [`SEEI_BYTE_W-1:0] status_wdata_in,
  output reg status_write_lock_out,
  output reg protect_level_hi_out,
  output reg protect_level_lo_out,
  output reg selected_out
);

  reg clk_s1_ff;
  reg clk_s2_ff;
  reg clk_s3_ff;
  reg sel_s1_ff;
  reg sel_s2_ff;
  reg din_s1_ff;
  reg din_s2_ff;
  reg [`SEEI_BIT_CNT_W-1:0] bit_cnt_ff;
  reg [`SEEI_BYTE_CNT_W-1:0] byte_cnt_ff;
  reg [`SEEI_BYTE_W-2:0] rx_sh_ff;
  reg [`SEEI_BYTE_W-1:0] tx_sh_ff;
  reg [`SEEI_BYTE_W-1:0] tx_hold_ff;
  reg push_ff;
  reg [`SEEI_BYTE_W-1:0] push_data_ff;
  wire active;
  wire clk_rise;
  wire clk_fall;
  wire push_ready;
  wire [`SEEI_BYTE_W-1:0] load_byte;
  wire byte_load;

  // A load slot is the falling edge that opens every byte after the first one;
  // both the output shifter and the transmit holding register act on it.
  function at_byte_load;
    input fall;
    input [`SEEI_BIT_CNT_W-1:0] bits;
    input [`SEEI_BYTE_CNT_W-1:0] bytes;
    begin
      at_byte_load = fall && (bits == {`SEEI_BIT_CNT_W{1'b0}}) &&
        (bytes != {`SEEI_BYTE_CNT_W{1'b0}});
    end
  endfunction

  // Two-stage synchronisers; the third clock stage only feeds edge finding.
  // Select resets high so that the block starts out deselected.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= spi_clk_in;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      sel_s1_ff <= spi_sel_n_in;
      sel_s2_ff <= sel_s1_ff;
      din_s1_ff <= spi_din_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // Edges count only while selected, so idle clock levels never matter.
  assign active = !sel_s2_ff;
  assign clk_rise = active && clk_s2_ff && !clk_s3_ff;
  assign clk_fall = active && !clk_s2_ff && clk_s3_ff;

  // Unloaded output bytes fall back to the erased value.
  assign load_byte = tx_ready_out ? `SEEI_ERASED_BYTE : tx_hold_ff;

  // Load slots only exist once the instruction byte has been clocked in.
  assign byte_load = at_byte_load(clk_fall, bit_cnt_ff, byte_cnt_ff);

  // Bit and byte counting plus input assembly on rising edges.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt_ff <= {`SEEI_BIT_CNT_W{1'b0}};
      byte_cnt_ff <= {`SEEI_BYTE_CNT_W{1'b0}};
      rx_sh_ff <= {(`SEEI_BYTE_W-1){1'b0}};
      push_ff <= 1'b0;
      push_data_ff <= {`SEEI_BYTE_W{1'b0}};
      rx_overflow_out <= 1'b0;
    end else begin
      // The push strobe lasts one cycle per completed byte.
      push_ff <= 1'b0;
      if (!active) begin
        bit_cnt_ff <= {`SEEI_BIT_CNT_W{1'b0}};
        byte_cnt_ff <= {`SEEI_BYTE_CNT_W{1'b0}};
      end else if (clk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + {{(`SEEI_BIT_CNT_W-1){1'b0}}, 1'b1};
        rx_sh_ff <= {rx_sh_ff[`SEEI_BYTE_W-3:0], din_s2_ff};
        // The eighth rising edge completes a byte.
        if (bit_cnt_ff == `SEEI_BIT_LAST) begin
          push_ff <= 1'b1;
          push_data_ff <= {rx_sh_ff, din_s2_ff};
          if (byte_cnt_ff != {`SEEI_BYTE_CNT_W{1'b1}}) begin
            byte_cnt_ff <= byte_cnt_ff + {{(`SEEI_BYTE_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      // Sticky flag: a full buffer drops the byte rather than stall the link.
      if (push_ff && !push_ready) begin
        rx_overflow_out <= 1'b1;
      end
    end
  end

  // Output shifting on falling edges once the instruction byte is in.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_sh_ff <= `SEEI_ERASED_BYTE;
      spi_dout_out <= 1'b1;
      spi_dout_oe_out <= 1'b0;
    end else begin
      spi_dout_oe_out <= active;
      // Falling edges during the instruction byte leave the output untouched.
      if (clk_fall && byte_cnt_ff != {`SEEI_BYTE_CNT_W{1'b0}}) begin
        if (bit_cnt_ff == {`SEEI_BIT_CNT_W{1'b0}}) begin
          spi_dout_out <= load_byte[`SEEI_BYTE_W-1];
          tx_sh_ff <= {load_byte[`SEEI_BYTE_W-2:0], 1'b1};
        end else begin
          spi_dout_out <= tx_sh_ff[`SEEI_BYTE_W-1];
          tx_sh_ff <= {tx_sh_ff[`SEEI_BYTE_W-2:0], 1'b1};
        end
      end
    end
  end

  // Transmit holding register; emptied when a byte boundary loads it.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_hold_ff <= `SEEI_ERASED_BYTE;
      tx_ready_out <= 1'b1;
    end else begin
      // An offer accepted in the very cycle of a load slot must not be lost:
      // the slot then sends the erased value and the new byte waits for the next.
      if (tx_valid_in && tx_ready_out) begin
        tx_hold_ff <= tx_data_in;
        tx_ready_out <= 1'b0;
      end else if (byte_load) begin
        tx_ready_out <= 1'b1;
      end
    end
  end

  // Status protection bits start in their delivery state.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_write_lock_out <= `SEEI_RST_WRITE_LOCK;
      protect_level_hi_out <= `SEEI_RST_PROTECT_HI;
      protect_level_lo_out <= `SEEI_RST_PROTECT_LO;
      selected_out <= 1'b0;
    end else begin
      // Selection is reported from the synchronised select, not the raw pin.
      selected_out <= active;
      if (status_wr_in) begin
        status_write_lock_out <= status_wdata_in[`SEEI_STAT_WRITE_LOCK];
        protect_level_hi_out <= status_wdata_in[`SEEI_STAT_PROTECT_HI];
        protect_level_lo_out <= status_wdata_in[`SEEI_STAT_PROTECT_LO];
      end
    end
  end

  // Received bytes wait here until the user side drains them.
  seei_fifo #(
    .WIDTH(`SEEI_BYTE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(push_data_ff),
    .wr_valid_in(push_ff),
    .wr_ready_out(push_ready),
    .rd_data_out(rx_data_out),
    .rd_valid_out(rx_valid_out),
    .rd_ready_in(rx_ready_in)
  );

endmodule

//--- dv/seei_spi_master_model.sv
// SPI bus master model for clock modes 0 and 3.
`timescale 1ns/1ps
module seei_spi_master_model (
  output logic spi_clk_out,
  output logic spi_sel_n_out,
  output logic spi_din_out,
  input wire spi_q_in
);
  logic cpol;
  // Idle: deselected with the clock parked low.
  initial begin
    cpol = 1'b0;
    spi_clk_out = 1'b0;
    spi_sel_n_out = 1'b1;
    spi_din_out = 1'b0;
  end
  // Parks the clock at the idle level of the mode.
  task automatic park(input logic pol);
    cpol = pol;
    spi_clk_out = pol;
  endtask
  // Selects one slave, off phase with the system clock.
  task automatic start();
    #37 spi_sel_n_out = 1'b0;
    #200;
  endtask
  // Shifts n bits each way, MSB first; reads just before the next fall.
  task automatic xfer(input logic [7:0] mo, input int n, output logic [7:0] mi);
    mi = 8'hff;
    for (int i = 7; i > 7 - n; i--) begin
      spi_clk_out = 1'b0;
      spi_din_out = mo[i];
      #200 spi_clk_out = 1'b1;
      #200 mi[i] = spi_q_in;
    end
  endtask
  // Ends a frame and releases the data line to a changed level.
  task automatic stop();
    spi_clk_out = cpol;
    #200 spi_sel_n_out = 1'b1;
    spi_din_out = ~spi_din_out;
    #200;
  endtask
  // Toggles clock and data while nobody is selected.
  task automatic noise();
    repeat (6) #100 {spi_clk_out, spi_din_out} = ~{spi_clk_out, spi_din_out};
    spi_clk_out = cpol;
  endtask
endmodule

//--- dv/seei_spi_slave_properties.sv
// Concurrent checks on the ports of the serial EEPROM SPI slave.
`timescale 1ns/1ps
module seei_spi_slave_properties (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire spi_clk_in,
  input wire spi_sel_n_in,
  input wire spi_dout_out,
  input wire spi_dout_oe_out,
  input wire selected_out,
  input wire [7:0] rx_data_out,
  input wire rx_valid_out,
  input wire rx_ready_in,
  input wire tx_valid_in,
  input wire tx_ready_out,
  input wire status_wr_in,
  input wire [7:0] status_wdata_in,
  input wire status_write_lock_out,
  input wire protect_level_hi_out,
  input wire protect_level_lo_out,
  input wire rx_overflow_out
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  wire [2:0] stat = {status_write_lock_out, protect_level_hi_out, protect_level_lo_out};
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // The output pin follows select with a short lag.
  AST_OE_OFF: assert property (spi_sel_n_in[*4] |-> !spi_dout_oe_out)
    else $error("output driven while deselected");
  AST_OE_ON: assert property ($fell(spi_sel_n_in) ##1 !spi_sel_n_in[*4] |-> spi_dout_oe_out)
    else $error("output not driven while selected");
  AST_SEL_OFF: assert property ($rose(spi_sel_n_in) |-> ##[1:4] !selected_out)
    else $error("select release not seen");
  // Protection bits change only through the write strobe.
  AST_STAT_UPD: assert property (status_wr_in |=> stat == {$past(status_wdata_in[7]),
    $past(status_wdata_in[3]), $past(status_wdata_in[2])})
    else $error("protection bits not written");
  AST_STAT_HOLD: assert property (!status_wr_in |=> $stable(stat))
    else $error("protection bits changed unasked");
  // Output data changes only after falling clock edges.
  AST_DOUT_HOLD: assert property (spi_clk_in[*3] |-> $stable(spi_dout_out))
    else $error("output moved while clock high");
  // Handshakes on the byte streams.
  AST_TX_TAKE: assert property (tx_valid_in && tx_ready_out |=> !tx_ready_out)
    else $error("transmit byte not taken");
  AST_RX_HOLD: assert property (rx_valid_out && !rx_ready_in |=>
    rx_valid_out && $stable(rx_data_out))
    else $error("receive head lost while stalled");
  COV_OVF: cover property ($rose(rx_overflow_out));
  COV_TX: cover property (tx_valid_in && tx_ready_out);
  COV_MODE3: cover property ($fell(spi_sel_n_in) && spi_clk_in);
endmodule

//--- dv/seei_spi_slave_tb_top.sv
// Self-checking bench of the serial EEPROM SPI slave.
`timescale 1ns/1ps
module seei_spi_slave_tb_top;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic tx_valid_in = 1'b0;
  logic status_wr_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic [7:0] status_wdata_in = 8'h00;
  wire spi_clk_in, spi_sel_n_in, spi_din_in, spi_dout_out, spi_dout_oe_out, spi_q;
  wire rx_valid_out, tx_ready_out, rx_overflow_out, selected_out;
  wire status_write_lock_out, protect_level_hi_out, protect_level_lo_out;
  wire [7:0] rx_data_out;
  logic [7:0] r;
  int n_fail = 0;
  int checked = 0;
  // ------------------------------------------------------------
  // Design, master model and shared data line
  // ------------------------------------------------------------
  assign spi_q = spi_dout_oe_out ? spi_dout_out : 1'bz;
  seei_spi_slave i_seei_spi_slave (.sys_clk_in, .resetn_in, .spi_clk_in, .spi_sel_n_in,
    .spi_din_in, .spi_dout_out, .spi_dout_oe_out, .rx_data_out, .rx_valid_out, .rx_ready_in,
    .rx_overflow_out, .tx_data_in, .tx_valid_in, .tx_ready_out, .status_wr_in,
    .status_wdata_in, .status_write_lock_out, .protect_level_hi_out, .protect_level_lo_out,
    .selected_out);
  seei_spi_master_model i_master (.spi_clk_out(spi_clk_in), .spi_sel_n_out(spi_sel_n_in),
    .spi_din_out(spi_din_in), .spi_q_in(spi_q));
  // System clock.
  always #25 sys_clk_in = ~sys_clk_in;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge sys_clk_in);
    #1;
  endtask
  // Waits a bounded time for the head byte, compares and pops it.
  task automatic pop(input logic [7:0] exp);
    for (int k = 0; k < 40 && rx_valid_out !== 1'b1; k++) step();
    chk({7'h0, rx_valid_out}, 8'h01);
    chk(rx_data_out, exp);
    rx_ready_in = 1'b1;
    step();
    rx_ready_in = 1'b0;
    step();
  endtask
  // Offers one byte for transmission once the hold register is free.
  task automatic offer(input logic [7:0] b);
    for (int k = 0; k < 40 && tx_ready_out !== 1'b1; k++) step();
    chk({7'h0, tx_ready_out}, 8'h01);
    tx_data_in = b;
    tx_valid_in = 1'b1;
    step();
    tx_valid_in = 1'b0;
  endtask
  task automatic wstat(input logic [7:0] w);
    status_wdata_in = w;
    status_wr_in = 1'b1;
    step();
    status_wr_in = 1'b0;
    step();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_status();
    chk({6'h0, spi_dout_out, spi_dout_oe_out}, 8'h02);
    chk({5'h0, status_write_lock_out, protect_level_hi_out, protect_level_lo_out}, 8'h00);
    wstat(8'h8c);
    chk({5'h0, status_write_lock_out, protect_level_hi_out, protect_level_lo_out}, 8'h07);
    wstat(8'h73);
    chk({5'h0, status_write_lock_out, protect_level_hi_out, protect_level_lo_out}, 8'h00);
  endtask
  task automatic t_frame(input logic pol);
    i_master.park(pol);
    offer(8'ha5);
    i_master.start();
    i_master.xfer(8'h03, 8, r);
    chk({6'h0, spi_dout_oe_out, selected_out}, 8'h03);
    i_master.xfer(8'h5a, 8, r);
    chk(r, 8'ha5);
    i_master.xfer(8'h81, 8, r);
    chk(r, 8'hff);
    i_master.stop();
    pop(8'h03);
    pop(8'h5a);
    pop(8'h81);
    chk({6'h0, spi_dout_oe_out, selected_out}, 8'h00);
  endtask
  task automatic t_deselect();
    i_master.park(1'b0);
    i_master.noise();
    repeat (8) step();
    chk({7'h0, rx_valid_out}, 8'h00);
    i_master.start();
    i_master.xfer(8'hc3, 3, r);
    i_master.stop();
    i_master.start();
    i_master.xfer(8'h96, 8, r);
    i_master.stop();
    pop(8'h96);
  endtask
  task automatic t_fill();
    chk({7'h0, rx_overflow_out}, 8'h00);
    i_master.start();
    for (int i = 0; i < 20; i++) i_master.xfer(i[7:0], 8, r);
    i_master.stop();
    chk({7'h0, rx_overflow_out}, 8'h01);
    for (int i = 0; i < 16; i++) pop(i[7:0]);
    rx_ready_in = 1'b1;
    repeat (8) step();
    rx_ready_in = 1'b0;
    chk({7'h0, rx_valid_out}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk_in);
    #1 resetn_in = 1'b1;
    step();
    t_status();
    t_frame(1'b0);
    t_frame(1'b1);
    t_deselect();
    t_fill();
    print_verdict();
  end
  // Watchdog.
  initial begin
    #3000000;
    n_fail++;
    print_verdict();
  end
endmodule
bind seei_spi_slave seei_spi_slave_properties i_props (.sys_clk_in, .resetn_in, .spi_clk_in,
  .spi_sel_n_in, .spi_dout_out, .spi_dout_oe_out, .selected_out, .rx_data_out, .rx_valid_out,
  .rx_ready_in, .tx_valid_in, .tx_ready_out, .status_wr_in, .status_wdata_in,
  .status_write_lock_out, .protect_level_hi_out, .protect_level_lo_out, .rx_overflow_out);
